// ===== hw/lfo_defines.vh
// constants for the oscillator start-up and output latch block
// How it works
// - after power-on reset, run start-up with the timer output held low
// - start-up lasts 500 master periods, independent of the divide ratio
// - divider-select code is resolved before start-up ends; output waits for it
// - polarity 0, hold low at start-up end: output starts toggling
// - polarity 0, hold high: pulses skipped until hold returns low
// - polarity 1: output low through start-up, high once start-up ends
// - polarity 1, hold high at end: output falls after one master period
// - polarity 1, hold low at end: latch held reset, output stays high
// - master clock divided by 1024 then by the programmable ratio
// - codes 0-7 polarity 0 ratios 8^n; codes 8-15 polarity 1 mirrored
// - hold active high for polarity 0, active low and output inverted for 1
// - code changes filtered, applied within 500 periods, no pulse under one period
`ifndef LFO_DEFINES_VH
`define LFO_DEFINES_VH
`define STARTUP_PERIODS    500
`define MASTER_PERIOD_CYC  1
`define STARTUP_CYCLES     (`STARTUP_PERIODS * `MASTER_PERIOD_CYC)
`define FILTER_CYCLES      16
`define HALF_PRE_SHIFT     5'h9
`define HALF_SHIFT_R0      5'h09
`define HALF_SHIFT_R1      5'h0c
`define HALF_SHIFT_R2      5'h0f
`define HALF_SHIFT_R3      5'h12
`define HALF_SHIFT_R4      5'h15
`define HALF_SHIFT_R5      5'h18
`define HALF_SHIFT_R6      5'h1b
`define HALF_SHIFT_R7      5'h1e
`define CODE_POL_BIT       3
`define DIV_CNT_W          31
`define START_CNT_W        10
`define FILT_CNT_W         5
`endif

// ===== hw/sync2.v
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sync2 #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_sync_b,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// ===== hw/lfo_startup.v
// start-up sequencer, divider and output latch of the low-frequency oscillator
`timescale 1ns/10ps
`include "lfo_defines.vh"
module lfo_startup #(
  parameter STARTUP_CYC = `STARTUP_CYCLES,
  parameter FILTER_CYC  = `FILTER_CYCLES
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [3:0] divider_select_code,
  input  wire       hold_in,
  output wire       timer_out,
  output wire       startup_done
);
  localparam ST_START = 1'b0;
  localparam ST_RUN   = 1'b1;

  reg                    rst_meta_q;
  reg                    rst_sync_q;
  wire                   rst_sync_b;
  wire [3:0]             code_s;
  wire                   hold_s;
  reg                    state_q;
  reg                    state_d;
  reg  [`START_CNT_W-1:0] start_cnt_d;
  wire                   start_full;
  wire                   settled;
  reg                    out_d;
  reg  [`START_CNT_W-1:0] start_cnt_q;
  reg  [3:0]             cand_code_q;
  reg  [`FILT_CNT_W-1:0] filt_cnt_q;
  reg  [3:0]             code_q;
  reg                    code_known_q;
  reg  [`DIV_CNT_W-1:0]  div_cnt_q;
  reg                    latch_q;
  reg                    out_q;
  wire                   output_polarity_select;
  wire [2:0]             ratio_idx;
  reg  [4:0]             half_shift;
  wire [`DIV_CNT_W-1:0]  half_term;
  wire                   hold_active;
  wire                   tick;
  wire                   start_end;

  // reset released through two flops
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_sync_b = rst_sync_q;

  sync2 #(.WIDTH(5)) u_sync (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .async_in   ({hold_in, divider_select_code}),
    .sync_out   ({hold_s, code_s})
  );

  // digital filter: any change restarts the settle count
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cand_code_q <= 4'h0;
      filt_cnt_q  <= {`FILT_CNT_W{1'b0}};
    end else if (code_s != cand_code_q) begin
      cand_code_q <= code_s;
      filt_cnt_q  <= {`FILT_CNT_W{1'b0}};
    end else if (!settled) begin
      filt_cnt_q <= filt_cnt_q + 1'b1;
    end
  end

  // settle count is far shorter than start-up, so the code is known in time
  assign settled = (code_s == cand_code_q) &&
                   (filt_cnt_q == FILTER_CYC[`FILT_CNT_W-1:0] - 1'b1);

  // applied code only moves once the candidate has settled
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      code_q <= 4'h0;
    end else if (settled) begin
      code_q <= cand_code_q;
    end
  end

  // known flag stays set until the next power-on reset
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      code_known_q <= 1'b0;
    end else if (settled) begin
      code_known_q <= 1'b1;
    end
  end

  // polarity and ratio index; upper half mirrors the lower
  assign output_polarity_select        = code_q[`CODE_POL_BIT];
  assign ratio_idx  = output_polarity_select ? ~code_q[2:0] : code_q[2:0];
  // half output period = 512 * 8^idx master periods
  // a table instead of arithmetic keeps the shift width obvious
  always @* begin
    case (ratio_idx)
      3'h0: begin
        half_shift = `HALF_SHIFT_R0;
      end
      3'h1: begin
        half_shift = `HALF_SHIFT_R1;
      end
      3'h2: begin
        half_shift = `HALF_SHIFT_R2;
      end
      3'h3: begin
        half_shift = `HALF_SHIFT_R3;
      end
      3'h4: begin
        half_shift = `HALF_SHIFT_R4;
      end
      3'h5: begin
        half_shift = `HALF_SHIFT_R5;
      end
      3'h6: begin
        half_shift = `HALF_SHIFT_R6;
      end
      3'h7: begin
        half_shift = `HALF_SHIFT_R7;
      end
      default: begin
        half_shift = `HALF_SHIFT_R0;
      end
    endcase
  end
  assign half_term  = ({{(`DIV_CNT_W-1){1'b0}}, 1'b1} << half_shift) - 1'b1;
  // >= so a shorter new ratio wraps at once instead of running to overflow
  assign tick       = (div_cnt_q >= half_term);
  assign hold_active = output_polarity_select ? ~hold_s : hold_s;
  assign start_full = (start_cnt_q == STARTUP_CYC[`START_CNT_W-1:0] - 1'b1);
  assign start_end  = start_full && code_known_q;

  // start-up counter; stretches if the code has not settled yet
  always @* begin
    state_d     = state_q;
    start_cnt_d = start_cnt_q;
    case (state_q)
      ST_START: begin
        if (start_end) begin
          state_d = ST_RUN;
        end else if (!start_full) begin
          start_cnt_d = start_cnt_q + 1'b1;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_START;
      end
    endcase
  end

  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q     <= ST_START;
      start_cnt_q <= {`START_CNT_W{1'b0}};
    end else begin
      state_q     <= state_d;
      start_cnt_q <= start_cnt_d;
    end
  end

  // divider keeps running under hold so output phase never shifts
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div_cnt_q <= {`DIV_CNT_W{1'b0}};
    end else if (state_q == ST_START) begin
      // preload so the first edge comes one master period after start-up
      div_cnt_q <= {`DIV_CNT_W{1'b1}};
    end else if (tick) begin
      div_cnt_q <= {`DIV_CNT_W{1'b0}};
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // output latch: hold wins over a divider tick in the same cycle
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      latch_q <= 1'b0;
    end else if (state_q == ST_START) begin
      latch_q <= 1'b0;
    end else if (hold_active) begin
      latch_q <= 1'b0;
    end else if (tick) begin
      latch_q <= ~latch_q;
    end
  end

  // low through start-up whatever the polarity
  always @* begin
    case (state_q)
      ST_RUN: begin
        out_d = latch_q ^ output_polarity_select;
      end
      default: begin
        out_d = 1'b0;
      end
    endcase
  end

  // registered so the pin never shows a decode glitch
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  assign timer_out    = out_q;
  assign startup_done = state_q;
endmodule

// ===== bench/lfo_startup_checker.sv
// assertions on the start-up sequencer ports
`timescale 1ns/10ps
module lfo_startup_checker #(
  parameter STARTUP_CYC = 500,
  parameter FILTER_CYC  = 16
) (
  input wire       clk,
  input wire       rst_b,
  input wire [3:0] divider_select_code,
  input wire       hold_in,
  input wire       timer_out,
  input wire       startup_done
);
  logic [15:0] cnt_q;
  wire         output_polarity_select = divider_select_code[3];
  // cycles since reset release, saturating
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_low_startup: assert property (!startup_done |-> !timer_out)
    else $error("output high in start-up");
  a_not_early: assert property ($rose(startup_done) |-> cnt_q >= STARTUP_CYC)
    else $error("start-up too short");
  // code is held steady through start-up, so this bound holds
  a_done_bound: assert property (cnt_q == STARTUP_CYC + 8 |-> startup_done)
    else $error("start-up too long");
  a_done_stays: assert property (startup_done |=> startup_done)
    else $error("start-up flag dropped");
  a_first_level: assert property ($rose(startup_done) |=> timer_out == output_polarity_select)
    else $error("wrong level after start-up");
  a_start_toggle: assert property ($rose(startup_done) && hold_in == output_polarity_select |=> ##1 timer_out != output_polarity_select)
    else $error("no toggle after start-up");
  a_held_start: assert property ($rose(startup_done) && hold_in != output_polarity_select |=> (timer_out == output_polarity_select)[*4])
    else $error("held output moved");
  a_hold_level: assert property ((startup_done && hold_in != output_polarity_select)[*6] |-> timer_out == output_polarity_select)
    else $error("hold level wrong");
  a_no_short: assert property ($rose(timer_out) && divider_select_code == 4'h0 && !hold_in |=> timer_out[*8])
    else $error("pulse too short");
endmodule
bind lfo_startup lfo_startup_checker #(.STARTUP_CYC(STARTUP_CYC), .FILTER_CYC(FILTER_CYC)) chk_inst (
  .clk(clk), .rst_b(rst_b), .divider_select_code(divider_select_code),
  .hold_in(hold_in), .timer_out(timer_out), .startup_done(startup_done));

// ===== bench/lfo_startup_test.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] t=%0t %h %h", $time, a, b); end end
module lfo_startup_test;
  localparam SCYC = 40;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] divider_select_code = 4'h0;
  logic       hold_in = 1'b0;
  wire        timer_out;
  wire        startup_done;
  int         fail_count = 0;
  int         checks_done = 0;
  int         n;
  logic       output_polarity_select;
  logic       act;
  always #10 clk = ~clk;
  // short start-up keeps each reset case quick
  lfo_startup #(.STARTUP_CYC(SCYC)) lfo_startup_inst (.clk(clk), .rst_b(rst_b),
    .divider_select_code(divider_select_code), .hold_in(hold_in),
    .timer_out(timer_out), .startup_done(startup_done));
  function automatic int half_of(input logic [3:0] c);
    logic [2:0] idx;
    idx = c[2:0] ^ {3{c[3]}};
    return 512 << (3 * idx);
  endfunction
  task automatic conclude;
    $display("mismatches %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // counts cycles until timer_out leaves lvl, bounded
  task automatic wait_out(input logic lvl, input int lim);
    n = 0;
    while (timer_out === lvl && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      conclude();
    end
  endtask
  initial begin
    void'($urandom(32'h1e04_4100));
    for (int k = 0; k < 4; k++) begin
      output_polarity_select = k[1];
      act = k[0];
      @(posedge clk);
      rst_b <= 1'b0;
      divider_select_code <= {output_polarity_select, 2'b11 & {2{output_polarity_select}}, output_polarity_select ^ 1'($urandom % 2)};
      hold_in <= output_polarity_select ^ act;
      tick(5);
      @(posedge clk);
      rst_b <= 1'b1;
      n = 0;
      while (startup_done !== 1'b1 && n < 300) begin
        tick(1);
        n++;
      end
      `CHK(n >= SCYC && n < 300, 1'b1)
      tick(1);
      `CHK(timer_out, output_polarity_select)
      tick(1);
      `CHK(timer_out, output_polarity_select ^ !act)
      if (!act) begin
        wait_out(timer_out, 5000);
        `CHK(n, half_of(divider_select_code))
      end else begin
        tick(600);
        `CHK(timer_out, output_polarity_select)
        @(posedge clk);
        hold_in <= ~hold_in;
        wait_out(output_polarity_select, half_of(divider_select_code) + 8);
        `CHK(timer_out, !output_polarity_select)
      end
    end
    conclude();
  end
endmodule
